/* File: pkg/csi_pkg.sv */
`default_nettype none
package csi_pkg;

    // avalon slave geometry
    localparam int CSI_ADDR_W = 28;
    localparam int CSI_DATA_W = 32;

    // register byte addresses
    localparam logic [27:0] CSI_CTL0_ADDR = 28'hffffd00;
    localparam logic [27:0] CSI_CTL1_ADDR = 28'hffffd04;
    localparam logic [27:0] CSI_LEN_ADDR = 28'hffffd08;
    localparam logic [27:0] CSI_STAT_ADDR = 28'hffffd0c;
    localparam logic [27:0] CSI_RX_ADDR = 28'hffffd10;
    localparam logic [27:0] CSI_TX_ADDR = 28'hffffd14;
    localparam logic [27:0] CSI_RXL_ADDR = 28'hffffd18;
    localparam logic [27:0] CSI_TXL_ADDR = 28'hffffd1c;

    // serial_control_zero field positions
    localparam int CSI_PWR_BIT = 7;
    localparam int CSI_TXE_BIT = 6;
    localparam int CSI_RXE_BIT = 5;
    localparam int CSI_DIR_BIT = 4;
    localparam int CSI_TMS_BIT = 1;
    localparam int CSI_SCE_BIT = 0;

    // clock/phase control field positions
    localparam int CSI_CKS_LSB = 0;
    localparam int CSI_SLV_BIT = 3;
    localparam int CSI_DAP_BIT = 4;
    localparam int CSI_CKP_BIT = 5;

    // status field positions
    localparam int CSI_BUSY_BIT = 7;
    localparam int CSI_OVE_BIT = 0;

    // values after reset
    localparam logic [7:0] CSI_CTL0_RST = 8'h01;
    localparam logic [7:0] CSI_CTL1_RST = 8'h00;
    localparam logic [3:0] CSI_LEN_RST = 4'h0;
    localparam logic [15:0] CSI_BUF_RST = 16'h0000;

    // word length limits
    localparam logic [4:0] CSI_LEN_MIN = 5'h08;
    localparam logic [4:0] CSI_LEN_MAX = 5'h10;

    // clock selection: codes below this divide the main clock, this code and above use the baud tick
    localparam logic [2:0] CSI_CKS_BAUD = 3'h6;
    localparam logic [5:0] CSI_DIV_BASE = 6'h02;

    // rate reference: fastest link at the reference main clock
    localparam int CSI_CORE_CLK_MHZ = 200;
    localparam int CSI_REF_FXX_MHZ = 20;
    localparam int CSI_MAX_RATE_MBPS = 5;
    localparam int CSI_CYC_PER_BIT_MIN = CSI_REF_FXX_MHZ / CSI_MAX_RATE_MBPS;

endpackage
`default_nettype wire

/* File: pkg/csi_shift_if.sv */
`default_nettype none
// carrier between the register side and the bit shifter
interface csi_shift_if;
    logic start;
    logic clr;
    logic [15:0] tx_word;
    logic [4:0] len;
    logic lsb_first;
    logic dap;
    logic lead;
    logic trail;
    logic sin;
    logic done;
    logic [15:0] rx_word;
    logic out_bit;

    modport ctl (
        output start, clr, tx_word, len, lsb_first, dap, lead, trail, sin,
        input done, rx_word, out_bit
    );
    modport sh (
        input start, clr, tx_word, len, lsb_first, dap, lead, trail, sin,
        output done, rx_word, out_bit
    );
endinterface
`default_nettype wire

/* File: design/csi_shifter.sv */
`default_nettype none
module csi_shifter
    import csi_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // control side
    csi_shift_if.sh sh
);

    typedef struct packed {
        logic [15:0] tx;
        logic [15:0] rx;
        logic [4:0] cnt;
        logic out;
    } csi_sh_state_t;

    csi_sh_state_t s_reg;
    csi_sh_state_t s_next;

    // position of the n-th bit on the wire inside the buffer word
    function automatic logic [3:0] csi_bit_idx(input logic [4:0] cnt, input logic [4:0] len,
                                               input logic lsb);
        logic [4:0] msb_idx;
        msb_idx = len - 5'h01 - cnt;
        csi_bit_idx = lsb ? cnt[3:0] : msb_idx[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // shift engine; rx starts at zero so unused high bits read back as zero
    always_comb begin
        s_next = s_reg;
        sh.done = 1'b0;
        if (sh.lead) begin
            if (sh.dap) begin
                s_next.out = s_reg.tx[csi_bit_idx(s_reg.cnt, sh.len, sh.lsb_first)];
            end else begin
                s_next.rx[csi_bit_idx(s_reg.cnt, sh.len, sh.lsb_first)] = sh.sin;
            end
        end
        if (sh.trail) begin
            if (sh.dap) begin
                s_next.rx[csi_bit_idx(s_reg.cnt, sh.len, sh.lsb_first)] = sh.sin;
            end
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_next.cnt == sh.len) begin
                sh.done = 1'b1;
            end else if (!sh.dap) begin
                s_next.out = s_reg.tx[csi_bit_idx(s_next.cnt, sh.len, sh.lsb_first)];
            end
        end
        // word handed over before a chained reload clears it, last bit included
        sh.rx_word = s_next.rx;
        // done must not depend on start, which the control side derives from done
        if (sh.clr) begin
            s_next = '0;
        end else if (sh.start) begin
            s_next.tx = sh.tx_word;
            s_next.rx = '0;
            s_next.cnt = '0;
            // late phase drives on the first edge, early phase before it
            s_next.out = sh.dap ? 1'b0 : sh.tx_word[csi_bit_idx(5'h00, sh.len, sh.lsb_first)];
        end
    end

    assign sh.out_bit = s_reg.out;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // csi_shifter
`default_nettype wire

/* File: design/csi_top.sv */
`default_nettype none
// Function
// - master drives serial clock, slave takes it from the link, chosen by a control bit.
// - word length programmable from 8 to 16 bits in one-bit steps.
// - serial clock idle level and data sampling phase are both selectable.
// - fastest setting gives 5 Mbps from a 20 MHz main clock.
// - shift clock from main clock divided 2..64 or from baud generator tick.
// - receive buffer 16 bits read-only, zero after reset and after power-off.
// - reading receive buffer with reception enabled and transmission disabled starts a receive transfer.
// - transmit buffer 16 bits read/write, zero at reset; write starts a transmit.
// - low bytes of both buffers also readable through separate byte aliases.
// - transmit and duplex start on buffer write; receive-only starts on buffer read.
// - control zero resets to 01h with power, enables, order, mode, trigger fields.
// - power bit low disables the port, resets internals and clears status.
// - serial data output held low while transmit is disabled.
// - with reception disabled, no buffer update, and no receive-complete interrupt in continuous mode.
// - bit order zero shifts MSB first, one shifts LSB first.
// - transfer mode zero is single, one is continuous.
// - single mode raises receive-complete per transfer, never transmit-ready.
// - single mode ignores start attempts while busy.
// - continuous mode chains a write made during a transfer into the next.
// - continuous receive-only restarts itself after each completion while the trigger bit is one.
// - late read in continuous receive-only sets the overrun flag.
// - start trigger bit zero blocks read-started receptions.
// - busy flag clears on the last clock edge of a transfer.
// - length code 0..7 gives 8..15 bits, top bit set gives 16.
// - overrun flag cleared by writing zero, never set by writing one.
// - receive-complete fires on data into the buffer and on overrun.
module csi_top
    import csi_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [CSI_ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [CSI_DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [CSI_DATA_W-1:0] o_readdata,
    output logic o_waitrequest,
    // serial link
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_oe,
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin,
    // clock source
    input wire logic i_baud_gen_clock,
    // interrupt requests
    output logic o_rx_complete_irq,
    output logic o_tx_ready_irq
);

    typedef struct packed {
        // serial_control_zero
        logic pwr;
        logic txe;
        logic rxe;
        logic lsb;
        logic tms;
        logic sce;
        // clock and phase control
        logic [2:0] cks;
        logic slave;
        logic dap;
        logic ckp;
        // length_control
        logic [3:0] len_code;
        // serial_status
        logic busy;
        logic ove;
        // data buffers
        logic [15:0] rx_buf;
        logic rx_full;
        logic [15:0] tx_buf;
        logic tx_pend;
        // link side
        logic [5:0] div_cnt;
        logic sck;
        logic sck_oe;
        logic sck_prev;
        logic sout;
        logic rx_irq;
        logic tx_irq;
        // bus side
        logic waitreq;
        logic [31:0] rdata;
    } csi_state_t;

    csi_state_t s_reg;
    csi_state_t s_next;

    csi_shift_if sh_if ();

    logic start_c;
    logic lead_c;
    logic trail_c;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // length code to bit count; any code with the top bit set means 16
    function automatic logic [4:0] csi_len(input logic [3:0] code);
        csi_len = code[3] ? CSI_LEN_MAX : CSI_LEN_MIN + {2'b00, code[2:0]};
    endfunction

    // one communication clock tick: divided main clock or baud generator
    function automatic logic csi_tick(input logic [5:0] cnt, input logic [2:0] cks,
                                      input logic bg);
        logic [5:0] div;
        div = CSI_DIV_BASE << cks;
        if (cks >= CSI_CKS_BAUD) begin
            csi_tick = bg;
        end else begin
            csi_tick = (cnt == div - 6'h01);
        end
    endfunction

    // register read view
    function automatic logic [31:0] csi_rd(input csi_state_t s, input logic [27:0] a);
        logic [7:0] b;
        b = 8'h00;
        csi_rd = 32'h0000_0000;
        if (a == CSI_CTL0_ADDR) begin
            b[CSI_PWR_BIT] = s.pwr;
            b[CSI_TXE_BIT] = s.txe;
            b[CSI_RXE_BIT] = s.rxe;
            b[CSI_DIR_BIT] = s.lsb;
            b[CSI_TMS_BIT] = s.tms;
            b[CSI_SCE_BIT] = s.sce;
            csi_rd = {24'h000000, b};
        end else if (a == CSI_CTL1_ADDR) begin
            b[CSI_CKS_LSB +: 3] = s.cks;
            b[CSI_SLV_BIT] = s.slave;
            b[CSI_DAP_BIT] = s.dap;
            b[CSI_CKP_BIT] = s.ckp;
            csi_rd = {24'h000000, b};
        end else if (a == CSI_LEN_ADDR) begin
            csi_rd = {28'h0000000, s.len_code};
        end else if (a == CSI_STAT_ADDR) begin
            b[CSI_BUSY_BIT] = s.busy;
            b[CSI_OVE_BIT] = s.ove;
            csi_rd = {24'h000000, b};
        end else if (a == CSI_RX_ADDR) begin
            csi_rd = {16'h0000, s.rx_buf};
        end else if (a == CSI_TX_ADDR) begin
            csi_rd = {16'h0000, s.tx_buf};
        end else if (a == CSI_RXL_ADDR) begin
            csi_rd = {24'h000000, s.rx_buf[7:0]};
        end else if (a == CSI_TXL_ADDR) begin
            csi_rd = {24'h000000, s.tx_buf[7:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic rd_acc;
        logic wr_acc;
        logic rx_read;
        logic tx_wr;
        logic tick;
        logic slv_edge;
        logic [7:0] d;
        rd_acc = i_read & ~s_reg.waitreq;
        wr_acc = i_write & ~s_reg.waitreq;
        rx_read = rd_acc & ((i_address == CSI_RX_ADDR) | (i_address == CSI_RXL_ADDR));
        tx_wr = 1'b0;
        d = i_writedata[7:0];
        tick = csi_tick(s_reg.div_cnt, s_reg.cks, i_baud_gen_clock);
        slv_edge = s_reg.busy & s_reg.slave & (i_serial_clock_pin != s_reg.sck_prev);
        s_next = s_reg;
        start_c = 1'b0;
        s_next.rx_irq = 1'b0;
        s_next.tx_irq = 1'b0;

        // bus: one wait cycle per request; data latched while waitrequest is high
        s_next.waitreq = ~((i_read | i_write) & s_reg.waitreq);
        if ((i_read | i_write) & s_reg.waitreq) begin
            s_next.rdata = csi_rd(s_reg, i_address);
        end

        // register writes
        if (wr_acc & i_byteenable[0]) begin
            if (i_address == CSI_CTL0_ADDR) begin
                s_next.pwr = d[CSI_PWR_BIT];
                s_next.sce = d[CSI_SCE_BIT];
                // mode fields locked while powered, settable in the power-up write
                if (!s_reg.pwr) begin
                    s_next.txe = d[CSI_TXE_BIT];
                    s_next.rxe = d[CSI_RXE_BIT];
                    s_next.lsb = d[CSI_DIR_BIT];
                    s_next.tms = d[CSI_TMS_BIT];
                end
            end else if (i_address == CSI_CTL1_ADDR && !s_reg.pwr) begin
                s_next.cks = d[CSI_CKS_LSB +: 3];
                s_next.slave = d[CSI_SLV_BIT];
                s_next.dap = d[CSI_DAP_BIT];
                s_next.ckp = d[CSI_CKP_BIT];
            end else if (i_address == CSI_LEN_ADDR && !(s_reg.pwr & (s_reg.txe | s_reg.rxe))) begin
                s_next.len_code = d[3:0];
            end else if (i_address == CSI_STAT_ADDR && !d[CSI_OVE_BIT]) begin
                s_next.ove = 1'b0;
            end
        end

        // transmit buffer write; ignored as a whole in single mode while busy
        if (wr_acc && i_address == CSI_TX_ADDR && |i_byteenable[1:0]
            && !(!s_reg.tms && s_reg.busy)) begin
            if (i_byteenable[0]) begin
                s_next.tx_buf[7:0] = i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                s_next.tx_buf[15:8] = i_writedata[15:8];
            end
            tx_wr = 1'b1;
        end

        // a read of the buffer frees it for the next word
        if (rx_read) begin
            s_next.rx_full = 1'b0;
        end

        // start conditions
        if (s_reg.pwr && !s_reg.busy) begin
            if (tx_wr && s_reg.txe) begin
                start_c = 1'b1;
            end else if (rx_read && s_reg.rxe && !s_reg.txe && s_reg.sce) begin
                start_c = 1'b1;
            end
        end else if (s_reg.pwr && tx_wr && s_reg.txe && s_reg.tms) begin
            s_next.tx_pend = 1'b1;
        end

        // shift clock source
        s_next.sck_prev = i_serial_clock_pin;
        if (s_reg.slave) begin
            lead_c = slv_edge & (i_serial_clock_pin != s_reg.ckp);
            trail_c = slv_edge & (i_serial_clock_pin == s_reg.ckp);
        end else begin
            lead_c = s_reg.busy & tick & (s_reg.sck == s_reg.ckp);
            trail_c = s_reg.busy & tick & (s_reg.sck != s_reg.ckp);
        end

        // master clock generation; idles at the selected level between words
        if (s_reg.busy && !s_reg.slave) begin
            s_next.div_cnt = tick ? 6'h00 : s_reg.div_cnt + 6'h01;
            if (tick) begin
                s_next.sck = ~s_reg.sck;
            end
        end else begin
            s_next.div_cnt = 6'h00;
            s_next.sck = s_reg.ckp;
        end

        // end of a word, taken on its final clock edge
        if (sh_if.done) begin
            s_next.busy = 1'b0;
            if (s_reg.rxe) begin
                s_next.rx_buf = sh_if.rx_word;
                s_next.rx_full = 1'b1;
                if (s_reg.rx_full && !rx_read) begin
                    s_next.ove = 1'b1;
                end
            end
            // single mode reports every completion; otherwise only receptions
            s_next.rx_irq = s_reg.rxe | ~s_reg.tms;
            if (s_reg.tms) begin
                if (s_reg.txe && s_reg.tx_pend) begin
                    start_c = 1'b1;
                end else if (!s_reg.txe && s_reg.rxe && s_reg.sce) begin
                    start_c = 1'b1;
                end
            end
        end

        // loading the shifter; in continuous transmit the buffer is free again
        if (start_c) begin
            s_next.busy = 1'b1;
            s_next.tx_pend = 1'b0;
            s_next.div_cnt = 6'h00;
            s_next.sck = s_reg.ckp;
            s_next.tx_irq = s_reg.tms & s_reg.txe;
        end

        // power off: abort, clock stopped, status and receive buffer cleared
        if (!s_next.pwr) begin
            start_c = 1'b0;
            s_next.busy = 1'b0;
            s_next.ove = 1'b0;
            s_next.rx_buf = CSI_BUF_RST;
            s_next.rx_full = 1'b0;
            s_next.tx_pend = 1'b0;
            s_next.sck = s_next.ckp;
            s_next.rx_irq = 1'b0;
            s_next.tx_irq = 1'b0;
        end

        // pins; data line low unless transmitting is enabled
        s_next.sout = s_reg.pwr & s_reg.txe & sh_if.out_bit;
        s_next.sck_oe = s_next.pwr & ~s_next.slave;
    end

    ////////////////////////////////////////////////////////////////////////////
    // shifter hookup
    assign sh_if.start = start_c;
    assign sh_if.clr = ~s_reg.pwr;
    assign sh_if.tx_word = s_next.tx_buf;
    assign sh_if.len = csi_len(s_reg.len_code);
    assign sh_if.lsb_first = s_reg.lsb;
    assign sh_if.dap = s_reg.dap;
    assign sh_if.lead = lead_c;
    assign sh_if.trail = trail_c;
    assign sh_if.sin = i_serial_in_pin;

    csi_shifter u_shifter (
        .i_core_clk (i_core_clk),
        .i_rstn (i_rstn),
        .sh (sh_if.sh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
            s_reg.sce <= CSI_CTL0_RST[CSI_SCE_BIT];
            s_reg.pwr <= CSI_CTL0_RST[CSI_PWR_BIT];
            s_reg.cks <= CSI_CTL1_RST[2:0];
            s_reg.len_code <= CSI_LEN_RST;
            s_reg.rx_buf <= CSI_BUF_RST;
            s_reg.tx_buf <= CSI_BUF_RST;
            s_reg.waitreq <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign o_readdata = s_reg.rdata;
    assign o_waitrequest = s_reg.waitreq;
    assign o_serial_clock_pin = s_reg.sck;
    assign o_serial_clock_oe = s_reg.sck_oe;
    assign o_serial_out_pin = s_reg.sout;
    assign o_rx_complete_irq = s_reg.rx_irq;
    assign o_tx_ready_irq = s_reg.tx_irq;

endmodule // csi_top
`default_nettype wire

/* File: tb/csi_sva.sv */
`default_nettype none
module csi_sva
    import csi_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // register bus
    input wire logic [CSI_ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [CSI_DATA_W-1:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [CSI_DATA_W-1:0] o_readdata,
    input wire logic o_waitrequest,
    // link and events
    input wire logic o_serial_clock_oe,
    input wire logic o_serial_out_pin,
    input wire logic o_rx_complete_irq,
    input wire logic o_tx_ready_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic take;
    //////////////////////////////////////////////////////////////////////
    // shadow of control zero; mode fields frozen while powered
    assign take = i_write && !o_waitrequest && i_address == CSI_CTL0_ADDR && i_byteenable[0];
    always_comb begin
        ctl_next = ctl_reg;
        if (take && ctl_reg[7]) begin
            ctl_next = {i_writedata[7], ctl_reg[6:4], 2'b00, ctl_reg[1], i_writedata[0]};
        end else if (take) begin
            ctl_next = {i_writedata[7:4], 2'b00, i_writedata[1:0]};
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl_reg <= CSI_CTL0_RST;
        end else begin
            ctl_reg <= ctl_next;
        end
    end
    //////////////////////////////////////////////////////////////////////
    // two-cycle antecedents: data out and transmit event are registered one cycle behind control
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    wait_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("request not answered after one wait cycle");
    wait_cause_a: assert property (!(i_read || i_write) |=> o_waitrequest)
        else $error("waitrequest low without request");
    ctl_read_a: assert property (i_read && !o_waitrequest && i_address == CSI_CTL0_ADDR
        |-> o_readdata == {24'h000000, ctl_reg}) else $error("control zero readback wrong");
    sout_low_a: assert property (!(ctl_reg[7] && ctl_reg[6]) && !$past(ctl_reg[7] && ctl_reg[6])
        |-> !o_serial_out_pin) else $error("data out not low while transmit off");
    oe_off_a: assert property (!ctl_reg[7] && !$past(ctl_reg[7]) |-> !o_serial_clock_oe)
        else $error("clock driven while unpowered");
    irq_power_a: assert property (!ctl_reg[7] && !$past(ctl_reg[7]) |-> !o_rx_complete_irq)
        else $error("receive event while unpowered");
    tx_irq_none_a: assert property (!ctl_reg[1] && !$past(ctl_reg[1]) |-> !o_tx_ready_irq)
        else $error("transmit event in single mode");
    rx_irq_pulse_a: assert property (o_rx_complete_irq |=> !o_rx_complete_irq)
        else $error("receive event longer than one cycle");
    cover property (o_rx_complete_irq);
    cover property (o_tx_ready_irq);
    cover property (o_serial_clock_oe && o_serial_out_pin);
endmodule // csi_sva
`default_nettype wire

/* File: tb/csi_peer.sv */
`default_nettype none
// far-side peripheral: captures on rising clock, shifts out after falling
module csi_peer (
    // link
    input wire logic i_sck,
    input wire logic i_oe,
    input wire logic i_sout,
    // preload and capture
    input wire logic i_load,
    input wire logic [15:0] i_word,
    output logic o_sin,
    output logic [15:0] o_cap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh_reg = 16'h0000;
    // sample where the device samples in the default phase
    always @(posedge i_sck) begin
        o_cap <= {o_cap[14:0], i_sout};
    end
    // msb first; a long frame just shifts in zeros
    always @(negedge i_sck or posedge i_load) begin
        if (i_load) begin
            sh_reg <= i_word;
        end else begin
            sh_reg <= {sh_reg[14:0], 1'b0};
        end
    end
    // undriven link shows the inverse so stale data cannot pass
    assign o_sin = i_oe ? sh_reg[15] : ~sh_reg[15];
endmodule // csi_peer
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top
    import csi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic load = 1'b0;
    logic [27:0] adr = 28'h0000000;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdata;
    logic [31:0] q;
    logic [15:0] pword = 16'h0000;
    logic [15:0] cap;
    logic wreq, sck, oe, sin, sout, rxi, txi;
    int n_errors = 0;
    int n_checks = 0;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

    always #2.5 clk = ~clk;

    csi_top DUT (
        .i_core_clk(clk), .i_rstn(rstn), .i_address(adr), .i_read(rd), .i_write(wr),
        .i_writedata(wd), .i_byteenable(4'hf), .o_readdata(rdata), .o_waitrequest(wreq),
        .i_serial_clock_pin(1'b0), .o_serial_clock_pin(sck), .o_serial_clock_oe(oe),
        .i_serial_in_pin(sin), .o_serial_out_pin(sout), .i_baud_gen_clock(1'b0),
        .o_rx_complete_irq(rxi), .o_tx_ready_irq(txi)
    );
    csi_peer peer (.i_sck(sck), .i_oe(oe), .i_sout(sout), .i_load(load), .i_word(pword),
        .o_sin(sin), .o_cap(cap));
    //////////////////////////////////////////////////////////////////////
    // one avalon transfer; request held until waitrequest seen low
    task automatic bus(input logic w, input logic [27:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        // no limit here: only the watchdog ends a wait
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // wait for a receive or transmit event, bounded
    task automatic wpulse(input logic tx);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((tx ? txi : rxi) !== 1'b1 && k < 400);
        `CHK("event", 1'b1, (tx ? txi : rxi))
    endtask
    task automatic widle();
        int k;
        k = 0;
        do begin
            bus(1'b0, CSI_STAT_ADDR, 32'h0);
            k++;
        end while (q[7] !== 1'b0 && k < 60);
        `CHK("busy", 1'b0, q[7])
    endtask
    task automatic pl(input logic [15:0] w);
        pword <= w;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // modes are changed only with power off first
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, CSI_CTL0_ADDR, 32'h0);
        `CHK("ctl0", 32'h01, q)
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        `CHK("rx", 32'h0, q)
        bus(1'b0, CSI_TX_ADDR, 32'h0);
        `CHK("tx", 32'h0, q)
        bus(1'b0, 28'hffffd20, 32'h0);
        `CHK("hole", 32'h0, q)
        $display("reset test done");
        pl(16'ha500);
        bus(1'b1, CSI_CTL0_ADDR, 32'hc1);
        bus(1'b1, CSI_TX_ADDR, 32'h3c);
        bus(1'b1, CSI_TX_ADDR, 32'h55);
        bus(1'b0, CSI_TX_ADDR, 32'h0);
        `CHK("tx busy", 32'h3c, q)
        `CHK("oe", 1'b1, oe)
        wpulse(1'b0);
        `CHK("far msb", 8'h3c, cap[7:0])
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        `CHK("rx off", 32'h0, q)
        bus(1'b1, CSI_CTL0_ADDR, 32'h00);
        pl(16'h9600);
        bus(1'b1, CSI_CTL0_ADDR, 32'hf1);
        bus(1'b1, CSI_TX_ADDR, 32'h01);
        wpulse(1'b0);
        `CHK("far lsb", 8'h80, cap[7:0])
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        `CHK("rx lsb", 32'h69, q)
        bus(1'b0, CSI_RXL_ADDR, 32'h0);
        `CHK("rx low", 32'h69, q)
        $display("single test done");
        bus(1'b1, CSI_CTL0_ADDR, 32'h00);
        bus(1'b1, CSI_LEN_ADDR, 32'h9);
        // clock idles high, late phase: the peer shifts before the first sample
        bus(1'b1, CSI_CTL1_ADDR, 32'h30);
        pl(16'hc3a5);
        bus(1'b1, CSI_CTL0_ADDR, 32'he1);
        bus(1'b1, CSI_TX_ADDR, 32'h1234);
        wpulse(1'b0);
        `CHK("far 16", 16'h1234, cap)
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        `CHK("rx 16", 32'h874a, q)
        bus(1'b1, CSI_TX_ADDR, 32'h00ff);
        bus(1'b1, CSI_CTL0_ADDR, 32'h00);
        bus(1'b0, CSI_STAT_ADDR, 32'h0);
        `CHK("stat off", 32'h0, q)
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        `CHK("rx off", 32'h0, q)
        `CHK("oe off", 1'b0, oe)
        bus(1'b1, CSI_CTL1_ADDR, 32'h08);
        bus(1'b1, CSI_CTL0_ADDR, 32'hc1);
        bus(1'b0, CSI_CTL0_ADDR, 32'h0);
        `CHK("slave oe", 1'b0, oe)
        bus(1'b1, CSI_CTL0_ADDR, 32'h00);
        bus(1'b1, CSI_CTL1_ADDR, 32'h00);
        bus(1'b1, CSI_LEN_ADDR, 32'h0);
        $display("length and abort test done");
        bus(1'b1, CSI_CTL0_ADDR, 32'hc3);
        bus(1'b1, CSI_TX_ADDR, 32'h5a);
        wpulse(1'b1);
        bus(1'b1, CSI_TX_ADDR, 32'h81);
        widle();
        `CHK("chain", 16'h5a81, cap)
        bus(1'b1, CSI_CTL0_ADDR, 32'h00);
        bus(1'b1, CSI_CTL0_ADDR, 32'ha3);
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        wpulse(1'b0);
        wpulse(1'b0);
        bus(1'b1, CSI_CTL0_ADDR, 32'ha2);
        widle();
        bus(1'b0, CSI_STAT_ADDR, 32'h0);
        `CHK("overrun", 1'b1, q[0])
        bus(1'b1, CSI_STAT_ADDR, 32'h0);
        bus(1'b1, CSI_STAT_ADDR, 32'h1);
        bus(1'b0, CSI_RX_ADDR, 32'h0);
        bus(1'b0, CSI_STAT_ADDR, 32'h0);
        `CHK("ovr clr", 32'h0, q)
        $display("continuous test done");
        results();
    end
    // run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule // tb_top

bind csi_top csi_sva chk (.i_core_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable, .o_readdata, .o_waitrequest, .o_serial_clock_oe, .o_serial_out_pin,
    .o_rx_complete_irq, .o_tx_ready_irq);
`default_nettype wire
